// >>> logic/seq_pkg.sv
// package: step sequencer constants, step encoding and carriers
package seq_pkg;
  // ---------------------------------------------------------------
  // sizes and limits
  // ---------------------------------------------------------------
  localparam int NUM_SEQ        = 50;
  localparam int SEQ_W          = 6;
  localparam int POS_W          = 5;
  localparam int LAST_TIMED_POS = 20;
  localparam int LAST_POS       = 21;
  localparam int SLOTS          = NUM_SEQ * LAST_POS;
  localparam int VAL_W          = 16;
  localparam int DUR_W          = 32;
  localparam int CALL_DEPTH     = 4;
  localparam int LOOP_DEPTH     = 10;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_NS  = 50;
  localparam int MS_NS     = 1000000;
  localparam int MS_CYCLES = MS_NS / CLOCK_NS;

  // ---------------------------------------------------------------
  // step encoding and carriers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    K_NOP, K_FIXED, K_VRAMP, K_CRAMP, K_POWER, K_REPEAT, K_CALL,
    K_RETURN, K_LOOP, K_NEXT, K_STOP, K_JUMP, K_PAUSE
  } kind_t;

  typedef logic [SEQ_W-1:0] seq_t;
  typedef logic [POS_W-1:0] pos_t;
  typedef logic [VAL_W-1:0] val_t;
  typedef logic [DUR_W-1:0] dur_t;

  // a..d hold the step's settings, dur is in milliseconds
  typedef struct packed {
    kind_t kind;
    val_t  a;
    val_t  b;
    val_t  c;
    val_t  d;
    dur_t  dur;
    seq_t  target;
  } step_t;

  typedef struct packed {
    logic  valid;
    seq_t  seq;
    pos_t  pos;
    step_t step;
  } define_t;

  typedef struct packed {
    val_t volts;
    val_t amps;
    val_t ovp;
    val_t watts;
    logic power_mode;
  } setpoint_t;

  typedef struct packed {
    seq_t seq;
    pos_t pos;
  } where_t;

  typedef struct packed {
    where_t at;
    val_t   left;
  } loop_t;
endpackage

// >>> logic/output_step_sequencer.sv
// sequence step store and executor for a programmable output
`timescale 1ns/100ps
module output_step_sequencer #(
  parameter int MS_TICKS = seq_pkg::MS_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire seq_pkg::define_t   define_cmd,
  input  wire logic               alloc_req,
  input  wire seq_pkg::seq_t      alloc_seq,
  input  wire logic               run_req,
  input  wire seq_pkg::seq_t      run_seq,
  input  wire logic               stop_req,
  input  wire logic               resume_req,
  output logic                    define_ack,
  output logic                    define_reject,
  output seq_pkg::setpoint_t      setpoint,
  output logic                    running,
  output logic                    paused,
  output seq_pkg::where_t         position,
  output logic                    fault
);
  import seq_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_EXEC, M_HOLD, M_SCALE, M_PAUSE} mode_t;

  typedef struct packed {
    mode_t                      mode;
    where_t                     at;
    seq_t                       start;
    setpoint_t                  sp;
    where_t [CALL_DEPTH-1:0]    calls;
    logic [2:0]                 call_depth;
    loop_t [LOOP_DEPTH-1:0]     loops;
    logic [3:0]                 loop_depth;
    dur_t                       hold_ms;
    dur_t                       elapsed;
    logic [DUR_W+1:0]           acc;
    logic                       ramp_on;
    logic                       ramp_amps;
    logic                       ramp_down;
    val_t                       ramp_span;
    val_t                       ramp_end;
    logic [31:0]                tick_cnt;
    logic [SLOTS-1:0]           filled;
    logic                       ack;
    logic                       reject;
    logic                       running;
    logic                       paused;
    logic                       fault;
  } state_t;

  localparam pos_t        FIRST_POS = 5'h01;
  localparam logic [31:0] TICK_LAST = 32'(MS_TICKS - 1);

  state_t s;
  state_t next_s;
  step_t  mem [SLOTS];
  step_t  cur;
  logic   here_ok;
  logic   def_ok;
  logic   alloc_ok;
  int     cur_idx;

  function automatic int slot(seq_t q, pos_t p);
    return int'(q) * LAST_POS + int'(p) - 1;
  endfunction

  // highest legal position for each kind of step
  function automatic int pos_limit(kind_t k);
    if (k == K_RETURN || k == K_STOP || k == K_JUMP) return LAST_POS;
    return LAST_TIMED_POS;
  endfunction

  // ---------------------------------------------------------------
  // step store
  // ---------------------------------------------------------------
  // a bad position never reaches the store, so an old step survives
  assign alloc_ok = alloc_req && (int'(alloc_seq) < NUM_SEQ);
  assign def_ok   = define_cmd.valid && !alloc_req
                    && (int'(define_cmd.seq) < NUM_SEQ)
                    && (define_cmd.pos >= FIRST_POS)
                    && (int'(define_cmd.pos) <= pos_limit(define_cmd.step.kind));

  // allocation wins a same-cycle clash with a definition
  always_ff @(posedge clock) begin
    if (alloc_ok) begin
      mem[slot(alloc_seq, POS_W'(LAST_POS))] <= '{kind: K_STOP, default: '0};
    end else if (def_ok) begin
      mem[slot(define_cmd.seq, define_cmd.pos)] <= define_cmd.step;
    end
  end

  // the executing step; an empty slot is never trusted
  assign here_ok = (s.at.pos >= FIRST_POS) && (int'(s.at.pos) <= LAST_POS)
                   && (int'(s.at.seq) < NUM_SEQ) && s.filled[slot(s.at.seq, s.at.pos)];
  assign cur_idx = here_ok ? slot(s.at.seq, s.at.pos) : 0;
  assign cur     = mem[cur_idx];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic             tick;
    logic [DUR_W+1:0] acc_in;
    loop_t            top;
    tick   = 1'b0;
    acc_in = '0;
    top    = '0;
    next_s = s;
    next_s.ack    = 1'b0;
    next_s.reject = 1'b0;

    // millisecond timebase, only runs while a timed step holds
    if (s.mode == M_HOLD || s.mode == M_SCALE) begin
      if (s.tick_cnt >= TICK_LAST) begin
        next_s.tick_cnt = '0;
        tick = 1'b1;
      end else begin
        next_s.tick_cnt = s.tick_cnt + 32'h1;
      end
    end else begin
      next_s.tick_cnt = '0;
    end
    if (tick) begin
      next_s.elapsed = s.elapsed + 32'h1;
    end
    acc_in = s.acc + ((tick && s.ramp_on) ? (DUR_W+2)'(s.ramp_span) : '0);
    next_s.acc = acc_in;

    // store bookkeeping
    if (alloc_ok) begin
      if (define_cmd.valid) next_s.reject = 1'b1;
      for (int p = 1; p <= LAST_POS; p++) begin
        next_s.filled[slot(alloc_seq, POS_W'(p))] = (p == LAST_POS);
      end
    end else if (def_ok) begin
      next_s.filled[slot(define_cmd.seq, define_cmd.pos)] = 1'b1;
      next_s.ack = 1'b1;
    end else if (define_cmd.valid) begin
      next_s.reject = 1'b1;
    end

    // run control; a host stop freezes the outputs where they are
    if (stop_req) begin
      next_s.mode = M_IDLE;
    end else if (run_req && int'(run_seq) < NUM_SEQ) begin
      next_s.mode       = M_EXEC;
      next_s.at         = '{seq: run_seq, pos: FIRST_POS};
      next_s.start      = run_seq;
      next_s.call_depth = '0;
      next_s.loop_depth = '0;
      next_s.fault      = 1'b0;
    end else begin
      unique case (s.mode)
        M_IDLE: ;
        M_PAUSE: begin
          if (resume_req) next_s.mode = M_EXEC;
        end
        M_HOLD: begin
          if (s.elapsed >= s.hold_ms) begin
            if (s.ramp_on && s.ramp_amps) next_s.sp.amps = s.ramp_end;
            if (s.ramp_on && !s.ramp_amps) next_s.sp.volts = s.ramp_end;
            next_s.ramp_on = 1'b0;
            next_s.mode = M_EXEC;
          end else if (s.ramp_on && acc_in >= (DUR_W+2)'(s.hold_ms)) begin
            next_s.mode = M_SCALE;
          end
        end
        // one unit of ramp per cycle, so a steep ramp on a short step lags
        M_SCALE: begin
          if (acc_in >= (DUR_W+2)'(s.hold_ms)) begin
            next_s.acc = acc_in - (DUR_W+2)'(s.hold_ms);
            if (s.ramp_amps) begin
              next_s.sp.amps = s.ramp_down ? s.sp.amps - 16'h1 : s.sp.amps + 16'h1;
            end else begin
              next_s.sp.volts = s.ramp_down ? s.sp.volts - 16'h1 : s.sp.volts + 16'h1;
            end
          end else begin
            next_s.mode = M_HOLD;
          end
        end
        M_EXEC: begin
          if (!here_ok) begin
            next_s.mode = M_IDLE;
          end else begin
            next_s.at.pos  = s.at.pos + 5'h01;
            next_s.elapsed = '0;
            next_s.acc     = '0;
            next_s.ramp_on = 1'b0;
            next_s.hold_ms = cur.dur;
            unique case (cur.kind)
              K_NOP: ;
              K_FIXED: begin
                next_s.sp.volts      = cur.a;
                next_s.sp.amps       = cur.b;
                next_s.sp.ovp        = cur.c;
                next_s.sp.power_mode = 1'b0;
                next_s.mode          = M_HOLD;
              end
              K_VRAMP: begin
                next_s.sp.volts      = cur.a;
                next_s.sp.amps       = cur.c;
                next_s.sp.ovp        = cur.d;
                next_s.sp.power_mode = 1'b0;
                next_s.ramp_on       = 1'b1;
                next_s.ramp_amps     = 1'b0;
                next_s.ramp_down     = cur.b < cur.a;
                next_s.ramp_span     = (cur.b < cur.a) ? cur.a - cur.b : cur.b - cur.a;
                next_s.ramp_end      = cur.b;
                next_s.mode          = M_HOLD;
              end
              K_CRAMP: begin
                next_s.sp.volts      = cur.a;
                next_s.sp.amps       = cur.b;
                next_s.sp.ovp        = cur.d;
                next_s.sp.power_mode = 1'b0;
                next_s.ramp_on       = 1'b1;
                next_s.ramp_amps     = 1'b1;
                next_s.ramp_down     = cur.c < cur.b;
                next_s.ramp_span     = (cur.c < cur.b) ? cur.b - cur.c : cur.c - cur.b;
                next_s.ramp_end      = cur.c;
                next_s.mode          = M_HOLD;
              end
              K_POWER: begin
                next_s.sp.watts      = cur.a;
                next_s.sp.volts      = cur.b;
                next_s.sp.amps       = cur.c;
                next_s.sp.ovp        = cur.d;
                next_s.sp.power_mode = 1'b1;
                next_s.mode          = M_HOLD;
              end
              K_REPEAT: next_s.at = '{seq: s.start, pos: FIRST_POS};
              K_CALL: begin
                if (int'(s.call_depth) == CALL_DEPTH) begin
                  next_s.fault = 1'b1;
                  next_s.mode  = M_IDLE;
                end else begin
                  next_s.calls[s.call_depth] = '{seq: s.at.seq, pos: s.at.pos + 5'h01};
                  next_s.call_depth = s.call_depth + 3'h1;
                  next_s.at = '{seq: cur.target, pos: FIRST_POS};
                end
              end
              K_RETURN: begin
                if (s.call_depth == '0) begin
                  next_s.mode = M_IDLE;
                end else begin
                  next_s.call_depth = s.call_depth - 3'h1;
                  next_s.at = s.calls[s.call_depth - 3'h1];
                end
              end
              K_LOOP: begin
                if (int'(s.loop_depth) == LOOP_DEPTH) begin
                  next_s.fault = 1'b1;
                  next_s.mode  = M_IDLE;
                end else begin
                  next_s.loops[s.loop_depth] = '{at: s.at, left: cur.a};
                  next_s.loop_depth = s.loop_depth + 4'h1;
                end
              end
              K_NEXT: begin
                if (s.loop_depth == '0) begin
                  next_s.fault = 1'b1;
                  next_s.mode  = M_IDLE;
                end else begin
                  top = s.loops[s.loop_depth - 4'h1];
                  if (top.left <= 16'h0001) begin
                    next_s.loop_depth = s.loop_depth - 4'h1;
                  end else begin
                    next_s.loops[s.loop_depth - 4'h1].left = top.left - 16'h0001;
                    next_s.at = '{seq: top.at.seq, pos: top.at.pos + 5'h01};
                  end
                end
              end
              K_STOP: next_s.mode = M_IDLE;
              K_JUMP: next_s.at = '{seq: cur.target, pos: FIRST_POS};
              K_PAUSE: next_s.mode = M_PAUSE;
              default: begin
                next_s.fault = 1'b1;
                next_s.mode  = M_IDLE;
              end
            endcase
          end
        end
      endcase
    end
    next_s.running = next_s.mode != M_IDLE;
    next_s.paused  = next_s.mode == M_PAUSE;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign define_ack    = s.ack;
  assign define_reject = s.reject;
  assign setpoint      = s.sp;
  assign running       = s.running;
  assign paused        = s.paused;
  assign position      = s.at;
  assign fault         = s.fault;
endmodule // output_step_sequencer

// >>> verif/output_step_sequencer_checker.sv
// checker: port properties of the step sequencer
`timescale 1ns/100ps
module output_step_sequencer_checker #(
  parameter int MS_TICKS = seq_pkg::MS_CYCLES
) (
  input wire logic               clock,
  input wire logic               rst,
  input wire seq_pkg::define_t   define_cmd,
  input wire logic               alloc_req,
  input wire seq_pkg::seq_t      alloc_seq,
  input wire logic               run_req,
  input wire seq_pkg::seq_t      run_seq,
  input wire logic               stop_req,
  input wire logic               resume_req,
  input wire logic               define_ack,
  input wire logic               define_reject,
  input wire seq_pkg::setpoint_t setpoint,
  input wire logic               running,
  input wire logic               paused,
  input wire seq_pkg::where_t    position,
  input wire logic               fault
);
  import seq_pkg::*;
  // ----
  // properties on the rising edge, off in reset
  // ----
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_answer_once: assert property (!(define_ack && define_reject))
    else $error("ack and reject together");
  a_def_answered: assert property (define_cmd.valid |=> define_ack || define_reject)
    else $error("definition not answered");
  a_pos0_refused: assert property (define_cmd.valid && define_cmd.pos == 5'h00 |=> define_reject)
    else $error("position 0 accepted");
  a_timed_pos21: assert property (define_cmd.valid && define_cmd.pos == 5'h15 &&
    define_cmd.step.kind inside {K_FIXED, K_VRAMP, K_CRAMP, K_POWER, K_REPEAT, K_CALL}
    |=> define_reject) else $error("timed step at 21 accepted");
  a_end_pos21: assert property (define_cmd.valid && define_cmd.pos == 5'h15 &&
    define_cmd.step.kind inside {K_RETURN, K_STOP} && define_cmd.seq < 6'h32 && !alloc_req
    |=> define_ack) else $error("end step at 21 refused");
  // a run of a sequence outside the store is ignored, so it is not watched here
  a_run_start: assert property (run_req && !stop_req && run_seq < 6'h32 |=> running &&
    position.pos == 5'h01 && position.seq == $past(run_seq)) else $error("run not at step 1");
  a_stop_ends: assert property (stop_req |=> !running)
    else $error("stop did not end run");
  // an idle sequencer never touches the output; a stop must leave it as it was
  a_idle_hold: assert property (!running && $past(!running) && !$past(run_req)
    |-> $stable(setpoint)) else $error("setpoint moved while idle");
  a_pause_hold: assert property (paused && !resume_req && !stop_req && !run_req
    |=> paused) else $error("pause left without resume");
  a_pause_power: assert property (paused && $past(paused) |-> $stable(setpoint))
    else $error("setpoint moved in pause");
  c_reject: cover property (define_reject);
  c_pause: cover property (paused && setpoint.power_mode);
  c_stop: cover property (stop_req && running);
endmodule // output_step_sequencer_checker

bind output_step_sequencer output_step_sequencer_checker #(.MS_TICKS(MS_TICKS)) checker_i (
  .clock(clock), .rst(rst), .define_cmd(define_cmd), .alloc_req(alloc_req),
  .alloc_seq(alloc_seq), .run_req(run_req), .run_seq(run_seq), .stop_req(stop_req),
  .resume_req(resume_req), .define_ack(define_ack), .define_reject(define_reject),
  .setpoint(setpoint), .running(running), .paused(paused), .position(position),
  .fault(fault));

// >>> verif/host.sv
// host model: definitions and run controls for the sequencer
`timescale 1ns/100ps
module host (
  input  wire logic           clock,
  input  wire logic           define_ack,
  input  wire logic           define_reject,
  output seq_pkg::define_t    define_cmd,
  output logic                alloc_req,
  output seq_pkg::seq_t       alloc_seq,
  output logic                run_req,
  output seq_pkg::seq_t       run_seq,
  output logic                stop_req,
  output logic                resume_req
);
  import seq_pkg::*;
  // ----
  // requests, changed on the falling edge only
  // ----
  initial begin
    define_cmd = '0;
    {alloc_req, resume_req, stop_req, run_req} = 4'h0;
    alloc_seq = '0;
    run_seq = '0;
  end
  // fields scrambled after release so a stale value cannot pass for a held one
  task automatic define(input seq_t s, input pos_t p, input step_t st, output logic [1:0] r);
    @(negedge clock);
    define_cmd = {1'b1, s, p, st};
    @(negedge clock);
    r = {define_ack, define_reject};
    define_cmd = {1'b0, ~s, ~p, ~st};
  endtask
  // one-cycle pulse: bit 0 run, 1 stop, 2 resume, 3 alloc
  task automatic pulse(input logic [3:0] m, input seq_t s);
    @(negedge clock);
    run_seq = s;
    alloc_seq = s;
    {alloc_req, resume_req, stop_req, run_req} = m;
    @(negedge clock);
    {alloc_req, resume_req, stop_req, run_req} = 4'h0;
    run_seq = ~s;
    alloc_seq = ~s;
  endtask
endmodule // host

// >>> verif/output_step_sequencer_tb.sv
// testbench: scenario tasks for the step sequencer
`timescale 1ns/100ps
module output_step_sequencer_tb;
  import seq_pkg::*;
  localparam int         MST = 4;
  localparam logic [1:0] ACK = 2'h2;
  localparam logic [1:0] REJ = 2'h1;
  logic      clock = 1'b0;
  logic      rst = 1'b1;
  define_t   define_cmd;
  logic      alloc_req, run_req, stop_req, resume_req, define_ack, define_reject;
  seq_t      alloc_seq, run_seq;
  setpoint_t setpoint;
  logic      running, paused, fault;
  where_t    position, watch, prev;
  int        hits, num_errors, checks_done;
  // ----
  // clock, design, host, entry counter
  // ----
  always #25 clock = ~clock;
  output_step_sequencer #(.MS_TICKS(MST)) output_step_sequencer_i (
    .clock(clock), .rst(rst), .define_cmd(define_cmd), .alloc_req(alloc_req),
    .alloc_seq(alloc_seq), .run_req(run_req), .run_seq(run_seq), .stop_req(stop_req),
    .resume_req(resume_req), .define_ack(define_ack), .define_reject(define_reject),
    .setpoint(setpoint), .running(running), .paused(paused), .position(position),
    .fault(fault));
  host host_i (.clock(clock), .define_ack(define_ack), .define_reject(define_reject),
    .define_cmd(define_cmd), .alloc_req(alloc_req), .alloc_seq(alloc_seq),
    .run_req(run_req), .run_seq(run_seq), .stop_req(stop_req), .resume_req(resume_req));
  // counts arrivals at the watched step, not cycles spent there
  always @(posedge clock) begin
    if (position !== prev && position === watch) hits++;
    prev = position;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic def(seq_t s, pos_t p, kind_t k, val_t a, val_t b, val_t c, val_t d, dur_t du);
    logic [1:0] r;
    host_i.define(s, p, step_t'{k, a, b, c, d, du, a[SEQ_W-1:0]}, r);
    chk("def", 16'(ACK), 16'(r));
  endtask
  // bounded wait; n is the number of falling edges spent running
  task automatic go(seq_t s, output int n);
    hits = 0;
    host_i.pulse(4'h1, s);
    n = 0;
    while (running !== 1'b0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk("run end", 16'h0, 16'(running));
  endtask
  task automatic t_define();
    logic [1:0] r;
    step_t      st;
    st = step_t'{K_FIXED, 16'h1, 16'h1, 16'h1, 16'h1, 32'h1, 6'h01};
    host_i.define(6'h01, 5'h00, st, r);
    chk("pos0", 16'(REJ), 16'(r));
    host_i.define(6'h32, 5'h01, st, r);
    chk("seq50", 16'(REJ), 16'(r));
    for (int k = 1; k <= 6; k++) begin
      st.kind = kind_t'(k);
      host_i.define(6'h01, 5'h15, st, r);
      chk("pos21", 16'(REJ), 16'(r));
    end
    def(6'h01, 5'h15, K_STOP, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h01, 5'h15, K_RETURN, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h01, 5'h14, K_FIXED, 16'h1, 16'h1, 16'h1, 16'h0, 32'h0);
  endtask
  task automatic t_fixed();
    int n;
    def(6'h02, 5'h01, K_FIXED, 16'h0064, 16'h00C8, 16'h012C, 16'h0, 32'h3);
    def(6'h02, 5'h02, K_STOP, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    go(6'h02, n);
    chk("hold", 16'h1, 16'(n >= 3 * MST && n <= 3 * MST + 6));
    chk("volts", 16'h0064, setpoint.volts);
    chk("amps", 16'h00C8, setpoint.amps);
    chk("ovp", 16'h012C, setpoint.ovp);
  endtask
  task automatic t_ramp();
    int n;
    def(6'h03, 5'h01, K_VRAMP, 16'h000A, 16'h0014, 16'h0005, 16'h0006, 32'h4);
    def(6'h03, 5'h02, K_CRAMP, 16'h001E, 16'h0001, 16'h0009, 16'h0007, 32'h4);
    def(6'h03, 5'h03, K_STOP, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    hits = 0;
    host_i.pulse(4'h1, 6'h03);
    repeat (12) @(negedge clock);
    chk("ramp amps", 16'h0005, setpoint.amps);
    chk("ramp mid", 16'h1, 16'(setpoint.volts > 16'h000A && setpoint.volts < 16'h0014));
    go(6'h03, n);
    chk("ramp end", 16'h0009, setpoint.amps);
    chk("ramp volts", 16'h001E, setpoint.volts);
  endtask
  // returns in a primary run must stop: the step after them would change volts
  task automatic t_call();
    int n;
    def(6'h04, 5'h01, K_CALL, 16'h0005, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h04, 5'h02, K_FIXED, 16'h0007, 16'h1, 16'h1, 16'h0, 32'h0);
    def(6'h04, 5'h03, K_RETURN, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h04, 5'h04, K_FIXED, 16'h0009, 16'h1, 16'h1, 16'h0, 32'h0);
    def(6'h05, 5'h01, K_FIXED, 16'h0005, 16'h1, 16'h1, 16'h0, 32'h0);
    def(6'h05, 5'h02, K_RETURN, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h06, 5'h01, K_JUMP, 16'h0005, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h06, 5'h02, K_FIXED, 16'h0008, 16'h1, 16'h1, 16'h0, 32'h0);
    watch = '{6'h05, 5'h01};
    go(6'h04, n);
    chk("called", 16'h1, 16'(hits));
    chk("resumed", 16'h0007, setpoint.volts);
    go(6'h06, n);
    chk("jumped", 16'h0005, setpoint.volts);
  endtask
  task automatic t_loop();
    int n;
    def(6'h07, 5'h01, K_LOOP, 16'hFFFF, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h07, 5'h01, K_LOOP, 16'h0003, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h07, 5'h02, K_LOOP, 16'h0002, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h07, 5'h03, K_FIXED, 16'h0004, 16'h1, 16'h1, 16'h0, 32'h0);
    def(6'h07, 5'h04, K_NEXT, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h07, 5'h05, K_NEXT, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h07, 5'h06, K_STOP, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    watch = '{6'h07, 5'h03};
    go(6'h07, n);
    chk("loop body", 16'h0006, 16'(hits));
    chk("loop fault", 16'h0, 16'(fault));
  endtask
  task automatic t_power();
    int n;
    def(6'h08, 5'h01, K_POWER, 16'h0032, 16'h000C, 16'h0004, 16'h000F, 32'h1);
    def(6'h08, 5'h02, K_PAUSE, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    def(6'h08, 5'h03, K_FIXED, 16'h000B, 16'h0002, 16'h000D, 16'h0, 32'h0);
    def(6'h08, 5'h04, K_STOP, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    host_i.pulse(4'h1, 6'h08);
    for (int i = 0; i < 100 && paused !== 1'b1; i++) @(negedge clock);
    repeat (5) @(negedge clock);
    chk("paused", 16'h1, 16'(paused));
    chk("power mode", 16'h1, 16'(setpoint.power_mode));
    chk("watts", 16'h0032, setpoint.watts);
    chk("volt limit", 16'h000C, setpoint.volts);
    host_i.pulse(4'h4, 6'h08);
    go(6'h3F, n);
    chk("power off", 16'h0, 16'(setpoint.power_mode));
    chk("after pause", 16'h000B, setpoint.volts);
  endtask
  task automatic t_repeat();
    int n;
    host_i.pulse(4'h8, 6'h02);
    go(6'h02, n);
    chk("emptied", 16'h000B, setpoint.volts);
    def(6'h09, 5'h01, K_FIXED, 16'h0001, 16'h1, 16'h1, 16'h0, 32'h0);
    def(6'h09, 5'h02, K_REPEAT, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    watch = '{6'h09, 5'h01};
    hits = 0;
    host_i.pulse(4'h1, 6'h09);
    repeat (40) @(negedge clock);
    chk("repeating", 16'h1, 16'(hits >= 3 && running === 1'b1));
    host_i.pulse(4'h2, 6'h09);
    chk("stopped", 16'h0, 16'(running));
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog: the scenarios need a few thousand cycles at most
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_define();
    t_fixed();
    t_ramp();
    t_call();
    t_loop();
    t_power();
    t_repeat();
    print_verdict();
  end
endmodule // output_step_sequencer_tb
